// ==== design/osbv_top.sv ====
// Fuse signature, burn sequencing and reload/verify control of the sensor.
// Assumes the programmer reaches registers by byte writes and reads on a
// simple address/data port, and that the fuse array is outside this block.
// How it works
// R1 - Signature covers bytes 0x02 to 0x1D ascending.
// R2 - Shift left, xor byte, xor 29 on carry.
// R3 - Lock clear means start in communication mode.
// R4 - Programmer resets DSP writing 0x20 to 0x23.
// R5 - Programmer reads angle at start and stop.
// R6 - Programmer writes 0x0A-0x1E and checks readback.
// R7 - Programmer rewrites with lock, reads for signature.
// R8 - Programmer writes signature, rewrites, verifies readback.
// R9 - Burn starts on 0x70@0x62 then 0x51@0x63.
// R10 - Burn completes within 10 ms.
// R11 - Programmer clears signature, selects guard threshold.
// R12 - Reload registers from fuses within 5 ms.
// R13 - Programmer compares reloaded signature and settings.
// R14 - Programmer repeats check at normal threshold.
// R15 - Failed guard check means part rejected.
// R16 - Guard threshold only for post-burn verification.
// R17 - Burned lock means functional mode after reset.
// R18 - Signature failure at normal threshold latches failure flag until reset.
// R19 - Stray or misordered burn writes are ignored.
`timescale 1ns/1ps
module osbv_top #(
	parameter int unsigned BURN_CYCLES = osbv_pkg::BURN_CYCLES,
	parameter int unsigned RELOAD_CYCLES = osbv_pkg::RELOAD_CYCLES,
	parameter int DEPTH = osbv_pkg::CFG_WORDS
) (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic [7:0] i_fuse_data,
	input wire logic i_fuse_lock,
	output logic [7:0] o_rdata,
	output logic o_rvalid,
	output logic o_comm_mode,
	output logic o_dsp_reset,
	output logic o_guard_band,
	output logic o_fuse_burn,
	output logic [4:0] o_fuse_addr,
	output logic o_busy,
	output logic [7:0] o_signature,
	output logic o_sig_fail
);
	localparam int AW = 5;
	osbv_pkg::osbv_state_t state;
	osbv_pkg::osbv_state_t next_state;
	logic [31:0] timer;
	logic [AW-1:0] idx;
	logic [7:0] misr;
	logic [7:0] dsp_ctrl;
	logic started;
	logic rd_pend;
	logic rd_special;
	logic [7:0] rd_special_val;
	logic [7:0] mem_rdata;
	logic rd_pend_host;
	logic rd_pend_host_special;
	logic [7:0] rd_hold;
	wire cfg_hit = i_addr < 8'(DEPTH);
	wire host_wr = i_wr && !o_busy;
	wire key1_hit = host_wr && i_addr == osbv_pkg::ADDR_KEY_FIRST && i_wdata == osbv_pkg::KEY_FIRST;
	wire key2_hit = host_wr && i_addr == osbv_pkg::ADDR_KEY_SECOND && i_wdata == osbv_pkg::KEY_SECOND;
	wire ctrl_wr = host_wr && i_addr == osbv_pkg::ADDR_DSP_CTRL;
	wire reload_go = ctrl_wr && o_comm_mode;
	wire timer_done = timer == 32'd0;
	wire reloading = state == osbv_pkg::ST_RELOAD;
	wire checking = state == osbv_pkg::ST_CHECK;
	wire mem_we = reloading || (host_wr && cfg_hit);
	wire [AW-1:0] mem_waddr = reloading ? idx : i_addr[AW-1:0];
	wire [7:0] mem_wdata = reloading ? i_fuse_data : i_wdata;
	wire [AW-1:0] mem_raddr = checking ? idx : i_addr[AW-1:0];
	wire [AW-1:0] prev_idx = idx - AW'(1);
	wire misr_in_range = prev_idx >= AW'(osbv_pkg::ADDR_SIG_FIRST) && prev_idx <= AW'(osbv_pkg::ADDR_SIG_LAST); // R1
	wire [7:0] misr_step = ({misr[6:0], 1'b0} ^ mem_rdata) ^ (misr[7] ? osbv_pkg::MISR_POLY : 8'h00); // R2
	wire last_idx = idx == AW'(DEPTH - 1);
	wire sig_ok = misr == mem_rdata;
	osbv_regmem #(
		.DEPTH(DEPTH),
		.AW(AW)
	) u_mem (
		.i_clock(i_clock),
		.i_we(mem_we),
		.i_waddr(mem_waddr),
		.i_wdata(mem_wdata),
		.i_raddr(mem_raddr),
		.o_rdata(mem_rdata)
	);
	always_comb
	begin
		next_state = state;
		unique case (state)
			osbv_pkg::ST_IDLE:
			begin
				if (key1_hit && o_comm_mode)
				begin
					next_state = osbv_pkg::ST_ARMED; // R9
				end
				else if (reload_go)
				begin
					next_state = osbv_pkg::ST_RELOAD; // R12
				end
			end
			osbv_pkg::ST_ARMED:
			begin
				if (key2_hit)
				begin
					next_state = osbv_pkg::ST_BURN; // R9
				end
				else if (host_wr || i_rd)
				begin
					next_state = osbv_pkg::ST_IDLE; // R19
				end
			end
			osbv_pkg::ST_BURN:
			begin
				if (timer_done)
				begin
					next_state = osbv_pkg::ST_IDLE; // R10
				end
			end
			osbv_pkg::ST_RELOAD:
			begin
				if (last_idx && timer_done)
				begin
					next_state = osbv_pkg::ST_CHECK;
				end
			end
			osbv_pkg::ST_CHECK:
			begin
				if (last_idx)
				begin
					next_state = osbv_pkg::ST_IDLE;
				end
			end
		endcase
	end
	assign rd_special = i_addr == osbv_pkg::ADDR_DSP_CTRL;
	assign rd_special_val = rd_special ? dsp_ctrl : osbv_pkg::ZERO_BYTE;
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
		begin
			state <= osbv_pkg::ST_IDLE;
			timer <= 32'd0;
			idx <= '0;
			misr <= 8'h00;
			dsp_ctrl <= 8'h00;
			started <= 1'b0;
			o_comm_mode <= 1'b0;
			o_dsp_reset <= 1'b0;
			o_guard_band <= 1'b0;
			o_fuse_burn <= 1'b0;
			o_fuse_addr <= '0;
			o_busy <= 1'b0;
			o_signature <= 8'h00;
			o_sig_fail <= 1'b0;
			o_rdata <= 8'h00;
			o_rvalid <= 1'b0;
			rd_pend <= 1'b0;
		end
		else
		begin
			state <= next_state;
			if (!started)
			begin
				started <= 1'b1;
				o_comm_mode <= !i_fuse_lock; // R3 R17
			end
			o_dsp_reset <= ctrl_wr && i_wdata == osbv_pkg::DSP_RESET_VALUE; // R4
			if (ctrl_wr)
			begin
				dsp_ctrl <= i_wdata;
				o_guard_band <= i_wdata == osbv_pkg::GUARD_THRESHOLD; // R11 R16
			end
			if (next_state == osbv_pkg::ST_BURN && state != osbv_pkg::ST_BURN)
			begin
				timer <= BURN_CYCLES - 1;
			end
			else if (next_state == osbv_pkg::ST_RELOAD && state == osbv_pkg::ST_IDLE)
			begin
				timer <= RELOAD_CYCLES - 1;
			end
			else if (!timer_done)
			begin
				timer <= timer - 32'd1;
			end
			o_fuse_burn <= next_state == osbv_pkg::ST_BURN; // R10
			o_busy <= next_state != osbv_pkg::ST_IDLE && next_state != osbv_pkg::ST_ARMED;
			if (state == osbv_pkg::ST_IDLE || (reloading && last_idx))
			begin
				idx <= '0;
				misr <= 8'h00;
			end
			else if (reloading || checking)
			begin
				idx <= idx + AW'(1);
			end
			o_fuse_addr <= reloading ? idx + AW'(1) : '0;
			if (checking && rd_pend && misr_in_range)
			begin
				misr <= misr_step; // R1
			end
			rd_pend <= checking && !last_idx;
			if (checking && last_idx)
			begin
				o_signature <= misr;
				if (!sig_ok && !o_guard_band)
				begin
					o_sig_fail <= 1'b1; // R18
				end
			end
			o_rvalid <= rd_pend_host;
			o_rdata <= rd_pend_host_special ? rd_hold : mem_rdata;
		end
	end
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
		begin
			rd_pend_host <= 1'b0;
			rd_pend_host_special <= 1'b0;
			rd_hold <= 8'h00;
		end
		else
		begin
			rd_pend_host <= i_rd && !o_busy;
			rd_pend_host_special <= !cfg_hit;
			rd_hold <= rd_special_val;
		end
	end
endmodule

// ==== design/osbv_pkg.sv ====
// Package for the fuse signature, burn and verify block.
// Assumes a 200 MHz clock and byte-wide register access.
package osbv_pkg;
	localparam int unsigned CLOCK_MHZ = 200;
	localparam int unsigned BURN_TIME_MS = 10;
	localparam int unsigned RELOAD_TIME_MS = 5;
	localparam int unsigned BURN_CYCLES = BURN_TIME_MS * 1000 * CLOCK_MHZ;
	localparam int unsigned RELOAD_CYCLES = RELOAD_TIME_MS * 1000 * CLOCK_MHZ;
	localparam logic [7:0] ADDR_SIG_FIRST = 8'h02;
	localparam logic [7:0] ADDR_SIG_LAST = 8'h1d;
	localparam logic [7:0] ADDR_LOCK = 8'h1d;
	localparam int unsigned LOCK_BIT = 7;
	localparam logic [7:0] ADDR_SIGNATURE = 8'h1e;
	localparam logic [7:0] ADDR_DSP_CTRL = 8'h23;
	localparam logic [7:0] ADDR_KEY_FIRST = 8'h62;
	localparam logic [7:0] ADDR_KEY_SECOND = 8'h63;
	localparam logic [7:0] KEY_FIRST = 8'h70;
	localparam logic [7:0] KEY_SECOND = 8'h51;
	localparam logic [7:0] DSP_RESET_VALUE = 8'h20;
	localparam logic [7:0] GUARD_THRESHOLD = 8'h40;
	localparam logic [7:0] NORMAL_THRESHOLD = 8'h00;
	localparam logic [7:0] MISR_POLY = 8'h1d;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam int unsigned CFG_WORDS = 32;
	typedef enum logic [2:0] {ST_IDLE, ST_ARMED, ST_BURN, ST_RELOAD, ST_CHECK} osbv_state_t;
endpackage

// ==== design/osbv_regmem.sv ====
// Configuration register memory with registered read data.
// Assumes one write and one read port access per clock.
`timescale 1ns/1ps
module osbv_regmem #(
	parameter int DEPTH = 32,
	parameter int AW = 5
) (
	input wire logic i_clock,
	input wire logic i_we,
	input wire logic [AW-1:0] i_waddr,
	input wire logic [7:0] i_wdata,
	input wire logic [AW-1:0] i_raddr,
	output logic [7:0] o_rdata
);
	logic [7:0] mem [DEPTH];
	always_ff @(posedge i_clock)
	begin
		if (i_we)
		begin
			mem[i_waddr] <= i_wdata;
		end
		o_rdata <= mem[i_raddr];
	end
endmodule

// ==== testbench/osbv_fuse.sv ====
// Fuse array model answering reload reads by address.
// Assumes the block samples the byte while it presents the address.
`timescale 1ns/1ps
module osbv_fuse (
	input wire logic i_bad,
	input wire logic [4:0] i_addr,
	output logic [7:0] o_data,
	output logic [7:0] o_sig
);
	initial
	begin
		o_sig = 8'h00;
		for (int a = 2; a < 30; a++)
			o_sig = {o_sig[6:0], 1'b0} ^ 8'(a * 37 + 5) ^ (o_sig[7] ? 8'h1d : 8'h00);
	end
	assign o_data = (i_addr == 5'h1e) ? (o_sig ^ {8{i_bad}}) : 8'(i_addr * 37 + 5);
endmodule

// ==== testbench/osbv_sva.sv ====
// Checker for the burn and reload behaviour at the top ports.
// Assumes a bind to osbv_top with the same burn count.
`timescale 1ns/1ps
module osbv_sva #(parameter int unsigned BURN_CYCLES = 20) (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_wr,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_fuse_lock,
	input wire logic o_comm_mode,
	input wire logic o_dsp_reset,
	input wire logic o_guard_band,
	input wire logic o_fuse_burn,
	input wire logic o_busy,
	input wire logic o_sig_fail
);
	default clocking @(posedge i_clock);
	endclocking
	default disable iff (i_rst);
	wire w = i_wr && !o_busy;
	wire k1 = w && o_comm_mode && i_addr == 8'h62 && i_wdata == 8'h70;
	wire k2 = w && o_comm_mode && i_addr == 8'h63 && i_wdata == 8'h51;
	wire c = w && o_comm_mode && i_addr == 8'h23;
	int unsigned n;
	always_ff @(posedge i_clock or posedge i_rst)
		if (i_rst)
			n <= 0;
		else
			n <= o_fuse_burn ? n + 1 : 0;
	burn_start_a: assert property (k1 ##1 k2 |-> ##[1:2] o_fuse_burn)
		else $error("burn not started");
	burn_key_a: assert property ($rose(o_fuse_burn) |-> $past(k2) || $past(k2, 2))
		else $error("burn without keys");
	burn_time_a: assert property (n <= BURN_CYCLES)
		else $error("burn too long");
	burn_busy_a: assert property (o_fuse_burn |-> o_busy)
		else $error("burn while idle");
	fail_stick_a: assert property (o_sig_fail |=> o_sig_fail)
		else $error("fail cleared");
	comm_mode_a: assert property ($rose(o_comm_mode) |-> !$past(i_fuse_lock))
		else $error("comm mode with lock");
	dsp_pulse_a: assert property (c && i_wdata == 8'h20 |-> ##[1:2] o_dsp_reset)
		else $error("no dsp reset");
	guard_set_a: assert property (c && i_wdata == 8'h40 |-> ##[1:2] o_guard_band)
		else $error("no guard band");
	reload_done_a: assert property (c |-> ##[1:2] o_busy ##[1:120] !o_busy)
		else $error("reload late");
	cover property ($rose(o_fuse_burn));
	cover property ($rose(o_sig_fail));
	cover property ($fell(o_guard_band));
endmodule

// ==== testbench/testbench.sv ====
// Self-checking bench for the burn, reload and signature block.
// Assumes the fuse model and checker are compiled first.
`timescale 1ns/1ps
module testbench;
	logic i_clock = 0, i_rst = 1, i_wr = 0, i_rd = 0, i_fuse_lock = 0, bad = 0;
	logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, i_fuse_data, o_rdata, o_signature, sig;
	logic o_rvalid, o_comm_mode, o_dsp_reset, o_guard_band, o_fuse_burn, o_busy, o_sig_fail;
	logic [4:0] o_fuse_addr;
	int failures = 0, total_checks = 0;
	osbv_top #(.BURN_CYCLES(20), .RELOAD_CYCLES(10)) dut_u (.*);
	osbv_fuse fu_u (.i_bad(bad), .i_addr(o_fuse_addr), .o_data(i_fuse_data), .o_sig(sig));
	initial
	forever #2.5 i_clock = ~i_clock;
	task chk(input string s, input logic [7:0] e, input logic [7:0] v);
		total_checks++;
		if (v !== e)
		begin
			failures++;
			$display("wrong value %s expected %h seen %h", s, e, v);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clock);
	endtask
	task idle;
		i_wr <= 1'b0;
		@(posedge i_clock);
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		i_wr <= 1'b0;
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clock);
		i_rd <= 1'b0;
		@(posedge i_clock);
		#1 chk("rdata", e, o_rdata);
		chk("rvalid", 8'h01, {7'h00, o_rvalid});
		@(posedge i_clock);
	endtask
	task burns(input logic [7:0] e);
		logic [7:0] n;
		n = 8'h00;
		i_wr <= 1'b0;
		repeat (40) @(negedge i_clock) n += o_fuse_burn;
		chk("burn", e, n);
		@(posedge i_clock);
	endtask
	task waitfree;
		idle;
		repeat (2) @(posedge i_clock);
		repeat (200) @(negedge i_clock) if (o_busy === 1'b0) break;
		chk("busy", 8'h00, {7'h00, o_busy});
		@(posedge i_clock);
	endtask
	task give_verdict;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial
	begin
		repeat (4) @(posedge i_clock);
		i_rst <= 1'b0;
		repeat (2) @(posedge i_clock);
		chk("comm", 8'h01, {7'h00, o_comm_mode});
		wr(8'h0a, 8'h5a);
		wr(8'h1e, 8'hc3);
		rd(8'h0a, 8'h5a);
		rd(8'h1e, 8'hc3);
		wr(8'h1d, 8'h80);
		rd(8'h1d, 8'h80);
		rd(8'h40, 8'h00);
		wr(8'h62, 8'h70);
		wr(8'h63, 8'h52);
		wr(8'h62, 8'h70);
		rd(8'h0a, 8'h5a);
		wr(8'h63, 8'h51);
		burns(8'h00);
		wr(8'h62, 8'h70);
		wr(8'h63, 8'h51);
		burns(8'h14);
		wr(8'h1e, 8'h00);
		wr(8'h23, 8'h40);
		#1 chk("guard", 8'h01, {7'h00, o_guard_band});
		waitfree;
		rd(8'h1e, sig);
		rd(8'h0a, 8'h77);
		chk("signature", sig, o_signature);
		wr(8'h23, 8'h20);
		#1 chk("dsp", 8'h01, {7'h00, o_dsp_reset});
		waitfree;
		chk("fail", 8'h00, {7'h00, o_sig_fail});
		bad <= 1'b1;
		wr(8'h23, 8'h00);
		waitfree;
		chk("fail", 8'h01, {7'h00, o_sig_fail});
		i_rst <= 1'b1;
		i_fuse_lock <= 1'b1;
		repeat (4) @(posedge i_clock);
		i_rst <= 1'b0;
		repeat (2) @(posedge i_clock);
		chk("comm", 8'h00, {7'h00, o_comm_mode});
		chk("fail", 8'h00, {7'h00, o_sig_fail});
		give_verdict;
	end
	initial
	begin
		#10000;
		failures++;
		give_verdict;
	end
endmodule
bind osbv_top osbv_sva #(.BURN_CYCLES(BURN_CYCLES)) chk_u (
	.i_clock(i_clock),
	.i_rst(i_rst),
	.i_wr(i_wr),
	.i_addr(i_addr),
	.i_wdata(i_wdata),
	.i_fuse_lock(i_fuse_lock),
	.o_comm_mode(o_comm_mode),
	.o_dsp_reset(o_dsp_reset),
	.o_guard_band(o_guard_band),
	.o_fuse_burn(o_fuse_burn),
	.o_busy(o_busy),
	.o_sig_fail(o_sig_fail)
);
